// *** common/lfbd_cfg.svh ***
// register indices, reset values, field positions and write masks of the line-feed bank
`ifndef LFBD_CFG_SVH
`define LFBD_CFG_SVH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define LFBD_ADDR_W        12
`define LFBD_IDX_W         7
`define LFBD_RESP_OKAY     2'h0
`define LFBD_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LFBD_IDX_MODE      7'h46
`define LFBD_IDX_HBV       7'h4E
`define LFBD_IDX_LBV       7'h4F
`define LFBD_IDX_LCL       7'h50
`define LFBD_IDX_ACL       7'h51
`define LFBD_IDX_COEFH     7'h52
`define LFBD_IDX_LC_ON     7'h53
`define LFBD_IDX_LC_OFF    7'h54
`define LFBD_IDX_TRIP_THR  7'h55
`define LFBD_IDX_OFFSET    7'h56
`define LFBD_IDX_MIN_ON    7'h57
`define LFBD_IDX_STATUS    7'h58

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LFBD_RST_HBV       8'h32
`define LFBD_RST_LBV       8'h10
`define LFBD_RST_ZERO      8'h00

// ----------------------------------------------------------------
// writable bits; everything else is reserved and reads zero
// ----------------------------------------------------------------
`define LFBD_MASK_HBV      8'hBF
`define LFBD_MASK_6BIT     8'h3F
`define LFBD_MASK_FULL     8'hFF
`define LFBD_MASK_LC_OFF   8'hFF
`define LFBD_MASK_OFFSET   8'h1F
`define LFBD_MASK_MODE     8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LFBD_BIT_EXT_BAT   7
`define LFBD_BIT_HYST      6
`define LFBD_BIT_DYN       7
`define LFBD_BIT_FOLLOW    4
`define LFBD_BIT_VBD       5
`define LFBD_BIT_OFFHOOK   0
`define LFBD_BIT_ACTRIP    1

`endif

// *** common/lfbd_pkg.sv ***
// types shared by the line-feed battery and detect register bank
`include "lfbd_cfg.svh"
package lfbd_pkg;

  // complete state of the bank: registers, bus handshake, detector results
  typedef struct packed {
    logic [7:0]              mode;
    logic [7:0]              hbv;
    logic [7:0]              lbv;
    logic [7:0]              lcl;
    logic [7:0]              acl;
    logic [7:0]              coefh;
    logic [7:0]              lc_on;
    logic [7:0]              lc_off;
    logic [7:0]              trip_thr;
    logic [7:0]              offset;
    logic [7:0]              min_on;
    logic                    aw_got;
    logic [`LFBD_ADDR_W-1:0] aw_addr;
    logic                    w_got;
    logic [7:0]              w_data;
    logic                    w_strb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
    logic                    off_hook;
    logic                    ac_trip;
    logic [5:0]              bat_target;
  } lfbd_state_type;

endpackage : lfbd_pkg

// *** logic/lfbd_regs.sv ***
// line-feed battery, loop-closure and ring-trip configuration bank with AXI4-Lite slave
`include "lfbd_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module lfbd_regs
  import lfbd_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic [`LFBD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`LFBD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic [5:0]              loop_current_code,
  input  wire logic [5:0]              tip_ring_voltage_code,
  input  wire logic [5:0]              ac_trip_current_code,
  input  wire logic [5:0]              ring_demand_level,
  output logic                         ext_battery_enable,
  output logic [5:0]                   high_battery_level,
  output logic [5:0]                   low_battery_level,
  output logic [11:0]                  loop_close_filter_coef,
  output logic [11:0]                  ac_trip_filter_coef,
  output logic                         hysteresis_enable,
  output logic                         dynamic_battery_target,
  output logic                         voltage_based_detect,
  output logic [5:0]                   ac_trip_current_threshold,
  output logic [3:0]                   tip_ring_offset,
  output logic                         battery_follow_enable,
  output logic [5:0]                   converter_min_on_count,
  output logic [5:0]                   battery_target_level,
  output logic                         off_hook,
  output logic                         ac_trip_detected
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // word index of a byte address
  function automatic logic [`LFBD_IDX_W-1:0] addr_index(input logic [`LFBD_ADDR_W-1:0] a);
    addr_index = a[`LFBD_IDX_W+1:2];
  endfunction : addr_index

  // aligned, within the decoded window and one of the listed words
  function automatic logic addr_mapped(input logic [`LFBD_ADDR_W-1:0] a);
    logic [`LFBD_IDX_W-1:0] i;
    i = a[`LFBD_IDX_W+1:2];
    addr_mapped = 1'b0;
    if ((a[1:0] == 2'h0) && (a[`LFBD_ADDR_W-1:`LFBD_IDX_W+2] == '0)) begin
      addr_mapped = (i == `LFBD_IDX_MODE) || (i == `LFBD_IDX_STATUS) ||
                    ((i >= `LFBD_IDX_HBV) && (i <= `LFBD_IDX_MIN_ON));
    end
  endfunction : addr_mapped

  // read view of one word; reserved bits come back zero
  function automatic logic [7:0] reg_read(input lfbd_state_type st,
                                          input logic [`LFBD_IDX_W-1:0] i);
    reg_read = 8'h00;
    unique case (i)
      `LFBD_IDX_MODE:   reg_read = st.mode;
      `LFBD_IDX_HBV:    reg_read = st.hbv;
      `LFBD_IDX_LBV:    reg_read = st.lbv;
      `LFBD_IDX_LCL:    reg_read = st.lcl;
      `LFBD_IDX_ACL:    reg_read = st.acl;
      `LFBD_IDX_COEFH:  reg_read = st.coefh;
      `LFBD_IDX_LC_ON:    reg_read = st.lc_on;
      `LFBD_IDX_LC_OFF:   reg_read = st.lc_off;
      `LFBD_IDX_TRIP_THR: reg_read = st.trip_thr;
      `LFBD_IDX_OFFSET:   reg_read = st.offset;
      `LFBD_IDX_MIN_ON:   reg_read = st.min_on;
      `LFBD_IDX_STATUS: begin
        reg_read[`LFBD_BIT_OFFHOOK] = st.off_hook;
        reg_read[`LFBD_BIT_ACTRIP]  = st.ac_trip;
      end
      default:          reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  lfbd_state_type s_reg;
  lfbd_state_type s_next;
  logic [5:0]     meas_code;
  logic [5:0]     on_thr;
  logic [5:0]     off_thr;
  logic           aw_fire;
  logic           w_fire;
  logic           ar_fire;

  // handshake outputs are combinational; a held response blocks new writes
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  // detector inputs: one measured quantity, thresholds cut to their low six bits
  assign meas_code = s_reg.mode[`LFBD_BIT_VBD] ? tip_ring_voltage_code
                                               : loop_current_code;
  assign on_thr    = s_reg.lc_on[5:0];
  assign off_thr   = s_reg.lc_off[5:0];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [`LFBD_IDX_W-1:0] widx;
    logic [7:0]             wv;
    widx   = '0;
    wv     = 8'h00;
    s_next = s_reg;

    // responses retire when taken; a new one is formed only after the held one has gone
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end

    // address and data are taken in either order and held until paired
    if (aw_fire) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_strb = s_axi_wstrb[0];
    end

    // write commits once both halves are in; unmapped words answer slverr
    if (s_next.aw_got && s_next.w_got && !s_reg.bvalid) begin
      widx          = addr_index(s_next.aw_addr);
      wv            = s_next.w_data;
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = addr_mapped(s_next.aw_addr) ? `LFBD_RESP_OKAY : `LFBD_RESP_SLVERR;
      if (addr_mapped(s_next.aw_addr) && s_next.w_strb) begin
        unique case (widx)
          `LFBD_IDX_MODE:  s_next.mode  = wv & `LFBD_MASK_MODE;
          `LFBD_IDX_HBV:   s_next.hbv   = wv & `LFBD_MASK_HBV;
          `LFBD_IDX_LBV:   s_next.lbv   = wv & `LFBD_MASK_6BIT;
          `LFBD_IDX_LCL:   s_next.lcl   = wv & `LFBD_MASK_FULL;
          `LFBD_IDX_ACL:   s_next.acl   = wv & `LFBD_MASK_FULL;
          `LFBD_IDX_COEFH: s_next.coefh = wv & `LFBD_MASK_FULL;
          `LFBD_IDX_LC_ON:    s_next.lc_on    = wv & `LFBD_MASK_6BIT;
          `LFBD_IDX_LC_OFF:   s_next.lc_off   = wv & `LFBD_MASK_LC_OFF;
          `LFBD_IDX_TRIP_THR: s_next.trip_thr = wv & `LFBD_MASK_6BIT;
          `LFBD_IDX_OFFSET:   s_next.offset   = wv & `LFBD_MASK_OFFSET;
          `LFBD_IDX_MIN_ON:   s_next.min_on   = wv & `LFBD_MASK_6BIT;
          default:         s_next.mode  = s_reg.mode;            // status is read-only
        endcase
      end
    end

    // read data is captured at the address edge and held until taken
    if (ar_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = addr_mapped(s_axi_araddr) ? reg_read(s_reg, addr_index(s_axi_araddr))
                                                : 8'h00;
      s_next.rresp  = addr_mapped(s_axi_araddr) ? `LFBD_RESP_OKAY : `LFBD_RESP_SLVERR;
    end

    // loop closure: with hysteresis each direction has its own threshold
    if (s_reg.lc_off[`LFBD_BIT_HYST]) begin
      if (!s_reg.off_hook) begin
        s_next.off_hook = (meas_code > on_thr);
      end else begin
        s_next.off_hook = !(meas_code < off_thr);
      end
    end else begin
      s_next.off_hook = (meas_code > on_thr);
    end

    // ac ring trip: raw comparison, debounce lives elsewhere
    s_next.ac_trip = (ac_trip_current_code > s_reg.trip_thr[5:0]);

    // battery target: fixed high level unless the dynamic target is on
    if (!s_reg.lc_off[`LFBD_BIT_DYN]) begin
      s_next.bat_target = s_reg.hbv[5:0];
    end else if (s_reg.offset[`LFBD_BIT_FOLLOW]) begin
      s_next.bat_target = ring_demand_level;
    end else begin
      // never below the low level, so the loop always has headroom
      s_next.bat_target = (ring_demand_level > s_reg.lbv[5:0]) ? ring_demand_level
                                                               : s_reg.lbv[5:0];
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg            <= '0;
      s_reg.hbv        <= `LFBD_RST_HBV;
      s_reg.lbv        <= `LFBD_RST_LBV;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // bus answers
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp  = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp  = s_reg.rresp;
  assign s_axi_rdata  = {24'h000000, s_reg.rdata};

  // settings consumed by the analog line feed, then the battery target and the detector results
  assign ext_battery_enable        = s_reg.hbv[`LFBD_BIT_EXT_BAT];
  assign high_battery_level        = s_reg.hbv[5:0];
  assign low_battery_level         = s_reg.lbv[5:0];
  assign loop_close_filter_coef    = {s_reg.coefh[3:0], s_reg.lcl};
  assign ac_trip_filter_coef       = {s_reg.coefh[7:4], s_reg.acl};
  assign hysteresis_enable         = s_reg.lc_off[`LFBD_BIT_HYST];
  assign dynamic_battery_target    = s_reg.lc_off[`LFBD_BIT_DYN];
  assign voltage_based_detect      = s_reg.mode[`LFBD_BIT_VBD];
  assign ac_trip_current_threshold = s_reg.trip_thr[5:0];
  assign tip_ring_offset           = s_reg.offset[3:0];
  assign battery_follow_enable     = s_reg.offset[`LFBD_BIT_FOLLOW];
  assign converter_min_on_count    = s_reg.min_on[5:0];
  assign battery_target_level      = s_reg.bat_target;
  assign off_hook                  = s_reg.off_hook;
  assign ac_trip_detected          = s_reg.ac_trip;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // a write taken in one cycle to a given word
  sequence wr_now(logic [`LFBD_IDX_W-1:0] i);
    aw_fire && w_fire && !s_reg.bvalid && s_axi_wstrb[0] &&
      (s_axi_awaddr == {3'h0, i, 2'h0});
  endsequence

  ext_battery_write_a: assert property (wr_now(`LFBD_IDX_HBV) |=>
    ext_battery_enable == $past(s_axi_wdata[7]))
    else $error("external battery enable does not follow write");

  low_level_default_a: assert property ($fell(sys_rst) |->
    low_battery_level == 6'(`LFBD_RST_LBV) && high_battery_level == 6'(`LFBD_RST_HBV))
    else $error("battery levels wrong after reset");

  loop_coef_join_a: assert property (wr_now(`LFBD_IDX_COEFH) |=>
    loop_close_filter_coef[11:8] == $past(s_axi_wdata[3:0]))
    else $error("loop coefficient high nibble wrong");

  ac_coef_join_a: assert property (wr_now(`LFBD_IDX_COEFH) |=>
    ac_trip_filter_coef[11:8] == $past(s_axi_wdata[7:4]))
    else $error("ac trip coefficient high nibble wrong");

  hyst_on_hold_a: assert property (hysteresis_enable && !off_hook &&
    (meas_code <= on_thr) |=> !off_hook)
    else $error("off-hook entered below on threshold");

  hyst_off_hold_a: assert property (hysteresis_enable && off_hook &&
    (meas_code >= off_thr) |=> off_hook)
    else $error("on-hook entered above off threshold");

  no_hyst_track_a: assert property (!hysteresis_enable |=>
    off_hook == ($past(meas_code) > $past(on_thr)))
    else $error("hook state wrong without hysteresis");

  follow_floor_a: assert property (dynamic_battery_target &&
    !battery_follow_enable ##1 $stable(low_battery_level) |->
    battery_target_level >= low_battery_level)
    else $error("battery target below low level");

  reserved_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000 && !(s_reg.hbv[6]))
    else $error("reserved bits read non-zero");

  write_answer_a: assert property (aw_fire && w_fire && !s_reg.bvalid |=>
    s_axi_bvalid ##0 s_axi_bvalid [*1])
    else $error("write not answered next cycle");

  trip_compare_a: assert property (1'b1 |=>
    ac_trip_detected == ($past(ac_trip_current_code) > $past(ac_trip_current_threshold)))
    else $error("ac trip compare wrong");

  // write-through of battery levels, hysteresis and target bits, offset, minimum on count and detect mode to their pins
  high_level_write_a: assert property (wr_now(`LFBD_IDX_HBV) |=>
    high_battery_level == $past(s_axi_wdata[5:0]))
    else $error("high battery level does not follow write");

  low_level_write_a: assert property (wr_now(`LFBD_IDX_LBV) |=>
    low_battery_level == $past(s_axi_wdata[5:0]))
    else $error("low battery level does not follow write");

  hyst_bit_write_a: assert property (wr_now(`LFBD_IDX_LC_OFF) |=>
    hysteresis_enable == $past(s_axi_wdata[6]))
    else $error("hysteresis enable does not follow write");

  dyn_bit_write_a: assert property (wr_now(`LFBD_IDX_LC_OFF) |=>
    dynamic_battery_target == $past(s_axi_wdata[7]))
    else $error("dynamic target enable does not follow write");

  offset_write_a: assert property (wr_now(`LFBD_IDX_OFFSET) |=>
    tip_ring_offset == $past(s_axi_wdata[3:0]))
    else $error("tip-ring offset does not follow write");

  min_on_write_a: assert property (wr_now(`LFBD_IDX_MIN_ON) |=>
    converter_min_on_count == $past(s_axi_wdata[5:0]))
    else $error("converter minimum on count does not follow write");

  detect_mode_write_a: assert property (wr_now(`LFBD_IDX_MODE) |=>
    voltage_based_detect == $past(s_axi_wdata[5]))
    else $error("detect mode does not follow write");

  // hook and battery decisions land one cycle behind their inputs
  hyst_engage_a: assert property (hysteresis_enable && !off_hook &&
    (meas_code > on_thr) |=> off_hook)
    else $error("off-hook missed above on threshold");

  hyst_drop_a: assert property (hysteresis_enable && off_hook &&
    (meas_code < off_thr) |=> !off_hook)
    else $error("on-hook missed below off threshold");

  fixed_target_a: assert property (!dynamic_battery_target |=>
    battery_target_level == $past(high_battery_level))
    else $error("battery target not the high level");

  follow_ring_a: assert property (dynamic_battery_target && battery_follow_enable |=>
    battery_target_level == $past(ring_demand_level))
    else $error("battery target does not follow ring demand");

  // main scenarios
  hyst_release_c: cover property (hysteresis_enable && off_hook ##1 !off_hook);
  strobe_off_c:   cover property (aw_fire && w_fire && !s_axi_wstrb[0]);
  voltage_mode_c: cover property (voltage_based_detect && $rose(off_hook));
  split_write_c:  cover property (aw_fire && !w_fire ##[1:4] w_fire);
  unmapped_rd_c:  cover property (s_axi_rvalid && s_axi_rresp == `LFBD_RESP_SLVERR);

endmodule : lfbd_regs

`default_nettype wire

// *** test/lfbd_regs_tb.sv ***
// self-checking bench of the line-feed battery and detect register bank
`timescale 1ns/10ps
`default_nettype none

module lfbd_regs_tb import lfbd_pkg::*; ;

  // ----------------------------------------------------------------
  // signals and the register model
  // ----------------------------------------------------------------
  logic        clk_sys, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr, loop_close_filter_coef, ac_trip_filter_coef;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, tip_ring_offset;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [5:0]  loop_current_code, tip_ring_voltage_code, ac_trip_current_code;
  logic [5:0]  ring_demand_level, high_battery_level, low_battery_level, battery_target_level;
  logic [5:0]  ac_trip_current_threshold, converter_min_on_count, q_lc, q_tv, q_ac, q_rd, meas;
  logic        ext_battery_enable, hysteresis_enable, dynamic_battery_target;
  logic        voltage_based_detect, battery_follow_enable, off_hook, ac_trip_detected, hk;
  logic [7:0]  d;
  logic [7:0]  ex [11];
  int          bad_count, samples_checked;
  // word indices; byte address is four times the index
  localparam logic [6:0] IDX [11] = '{7'h46, 7'h4E, 7'h4F, 7'h50, 7'h51, 7'h52, 7'h53, 7'h54,
                                      7'h55, 7'h56, 7'h57};
  localparam logic [7:0] MSK [11] = '{8'h20, 8'hBF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
                                      8'h3F, 8'h1F, 8'h3F};
  localparam logic [7:0] RST [11] = '{8'h00, 8'h32, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h00};

  lfbd_regs uut (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .loop_current_code, .tip_ring_voltage_code,
    .ac_trip_current_code, .ring_demand_level, .ext_battery_enable, .high_battery_level,
    .low_battery_level, .loop_close_filter_coef, .ac_trip_filter_coef, .hysteresis_enable,
    .dynamic_battery_target, .voltage_based_detect, .ac_trip_current_threshold, .tip_ring_offset,
    .battery_follow_enable, .converter_min_on_count, .battery_target_level, .off_hook,
    .ac_trip_detected);

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  // a wait that runs out counts as a mismatch and ends the run
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      bad_count++;
      conclude();
    end
  endtask : tmo

  // address and data offered together; each dropped at the edge it is taken
  task automatic axi_write(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
    int n;
    logic at, wt, ad, wd;
    ad = 0;
    wd = 0;
    at = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40 && !(ad && wd); n++) begin
      @(negedge clk_sys);
      at = s_axi_awvalid & s_axi_awready;
      wt = s_axi_wvalid & s_axi_wready;
      @(posedge clk_sys);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      ad = ad | at;
      wd = wd | wt;
    end
    at = 0;
    for (n = 0; n < 40 && !at && ad && wd; n++) begin
      @(negedge clk_sys);
      at = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk_sys);
    end
    s_axi_bready <= 1'b0;
    tmo(at);
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [7:0] v, output logic [1:0] rs);
    int n;
    logic t;
    t = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40 && !t; n++) begin
      @(negedge clk_sys);
      t = s_axi_arready;
      @(posedge clk_sys);
    end
    s_axi_arvalid <= 1'b0;
    for (n = 0; n < 40 && t && !s_axi_rvalid; n++) @(negedge clk_sys);
    tmo(s_axi_rvalid === 1'b1);
    chk(s_axi_rdata[31:8], 0);
    v = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wreg(input int k, input logic [7:0] v);
    axi_write({3'h0, IDX[k], 2'h0}, v, r);
    chk(r, 0);
    ex[k] = v & MSK[k];
  endtask : wreg

  task automatic rall();
    for (int k = 0; k < 11; k++) begin
      axi_read({3'h0, IDX[k], 2'h0}, d, r);
      chk(d, ex[k]);
      chk(r, 0);
    end
    chk(ext_battery_enable, ex[1][7]);
    chk(high_battery_level, ex[1][5:0]);
    chk(low_battery_level, ex[2][5:0]);
    chk(loop_close_filter_coef, {ex[5][3:0], ex[3]});
    chk(ac_trip_filter_coef, {ex[5][7:4], ex[4]});
    chk(hysteresis_enable, ex[7][6]);
    chk(dynamic_battery_target, ex[7][7]);
    chk(voltage_based_detect, ex[0][5]);
    chk(ac_trip_current_threshold, ex[8][5:0]);
    chk(tip_ring_offset, ex[9][3:0]);
    chk(battery_follow_enable, ex[9][4]);
    chk(converter_min_on_count, ex[10][5:0]);
  endtask : rall

  // ----------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {loop_current_code, tip_ring_voltage_code, ac_trip_current_code, ring_demand_level} = '0;
    s_axi_wstrb = 4'hF;
    sys_rst = 1'b1;
    void'($urandom(32'hDB1B));
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    ex = RST;
    rall();
    // all-ones first so reserved bits are exercised, then random patterns
    for (int p = 0; p < 3; p++) begin
      for (int k = 0; k < 11; k++) wreg(k, p == 0 ? 8'hFF : 8'($urandom));
      rall();
    end
    // status ignores writes; unmapped and misaligned places refuse with an error
    axi_write(12'h160, 8'hFF, r);
    chk(r, 0);
    axi_read(12'h160, d, r);
    chk(d, 0);
    foreach (IDX[j]) if (j < 3) begin
      axi_write(j == 0 ? 12'h200 : (j == 1 ? 12'h139 : 12'h004), 8'hA5, r);
      chk(r, 2);
      axi_read(j == 0 ? 12'h200 : (j == 1 ? 12'h139 : 12'h004), d, r);
      chk({r, d}, 10'h200);
    end
    // lane 0 unstrobed: answered but the word keeps its value
    s_axi_wstrb <= 4'h0;
    axi_write({3'h0, IDX[3], 2'h0}, ~ex[3], r);
    chk(r, 0);
    s_axi_wstrb <= 4'hF;
    rall();
    // every mix of detect mode, hysteresis, dynamic target and tracking
    for (int c = 0; c < 16; c++) begin
      wreg(0, {2'h0, c[0], 5'h0});
      wreg(7, {c[2], c[1], 6'($urandom_range(63, 1))});
      wreg(9, {3'h0, c[3], 4'($urandom)});
      wreg(6, 8'($urandom));
      wreg(8, 8'($urandom));
      wreg(1, 8'($urandom));
      wreg(2, 8'($urandom));
      hk = 1'b0;
      for (int i = 0; i < 25; i++) begin
        @(posedge clk_sys);
        {q_lc, q_tv, q_ac, q_rd} = {loop_current_code, tip_ring_voltage_code,
                                    ac_trip_current_code, ring_demand_level};
        {loop_current_code, tip_ring_voltage_code} <= i == 24 ? 12'h0 : 12'($urandom);
        {ac_trip_current_code, ring_demand_level} <= i == 24 ? 12'h0 : 12'($urandom);
        @(negedge clk_sys);
        meas = ex[0][5] ? q_tv : q_lc;
        if (!ex[7][6]) hk = meas > ex[6][5:0];
        else if (!hk) hk = meas > ex[6][5:0];
        else hk = !(meas < ex[7][5:0]);
        chk(off_hook, hk);
        chk(ac_trip_detected, q_ac > ex[8][5:0]);
        chk(battery_target_level, !ex[7][7] ? ex[1][5:0] : (ex[9][4] || q_rd > ex[2][5:0])
            ? q_rd : ex[2][5:0]);
      end
    end
    rall();
    conclude();
  end

endmodule : lfbd_regs_tb

`default_nettype wire
